// ### dv/test_trc_resource_regs.sv
`timescale 1ns/100ps
module test_trc_resource_regs;
    logic                  mclk;
    logic                  rst_n;
    trc_pkg::trc_bus_req_s bus;
    logic [31:0]           rdata;
    logic [15:0]           addr_hit;
    logic [31:0]           cur_context_id;
    logic [7:0]            cur_vmid;
    trc_pkg::trc_cnt_ev_s  cnt_ev;
    logic                  seq_ev_valid;
    logic [1:0]            seq_ev_state;
    logic                  trace_byte;
    logic [15:0]           addr_match;
    logic [2:0]            ctx_match;
    logic                  vmid_match;
    logic [3:0]            cnt_at_zero;
    logic [1:0]            seq_state;
    logic                  sync_req;
    logic [31:0]           ext_sel;
    logic                  branch_all;
    logic                  cyc_acc;
    logic [31:0]           exp_q[$];
    logic                  rd_seen = 1'b0;
    int                    fails = 0;
    int                    checks_done = 0;
    int                    cyc = 0;
    int                    sync_cnt = 0;

    trc_resource_regs dut (
        .mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .addr_hit(addr_hit),
        .cur_context_id(cur_context_id), .cur_vmid(cur_vmid), .cnt_ev(cnt_ev),
        .seq_ev_valid(seq_ev_valid), .seq_ev_state(seq_ev_state), .trace_byte(trace_byte),
        .addr_match(addr_match), .ctx_match(ctx_match), .vmid_match(vmid_match),
        .cnt_at_zero(cnt_at_zero), .seq_state(seq_state), .sync_req(sync_req),
        .ext_sel(ext_sel), .branch_all(branch_all), .cyc_acc(cyc_acc)
    );

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge mclk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        bus <= '0;
    endtask

    // the expected word is queued; the monitor compares it a cycle after the strobe
    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        @(posedge mclk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge mclk);
        bus <= '0;
    endtask

    // ------------------------------------------------------------
    // monitor and timeout
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (rd_seen) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("mismatch at %0t: unexpected read data", $time);
            end else begin
                check(rdata, exp_q.pop_front());
            end
        end
        rd_seen <= bus.rd & rst_n;
        if (sync_req === 1'b1) sync_cnt++;
        cyc++;
        if (cyc == 5000) begin
            fails++;
            $display("mismatch at %0t: run did not finish", $time);
            test_done();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [31:0] v [3];
        logic [9:0]  rw_addr [9];
        logic [31:0] rw_mask [9];
        logic [1:0]  sq [3];
        int          k;
        bus = '0;
        rst_n = 1'b0;
        addr_hit = '0;
        cur_context_id = '0;
        cur_vmid = '0;
        cnt_ev = '0;
        seq_ev_valid = 1'b0;
        seq_ev_state = 2'h0;
        trace_byte = 1'b0;
        rw_addr = '{trc_pkg::REG_CNT_RLD, trc_pkg::REG_CNT_RLD + 10'h3, trc_pkg::REG_CID_VAL,
                    trc_pkg::REG_CID_VAL + 10'h1, trc_pkg::REG_CID_VAL + 10'h2,
                    trc_pkg::REG_CID_MASK, trc_pkg::REG_VMID, trc_pkg::REG_SYNC,
                    trc_pkg::REG_EXT_SEL};
        rw_mask = '{32'hffff, 32'hffff, '1, '1, '1, '1, 32'hff, 32'hfff, '1};
        sq = '{trc_pkg::SEQ_STATE2, trc_pkg::SEQ_STATE3, trc_pkg::SEQ_STATE1};
        void'($urandom(32'h6cf6));
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        rd(trc_pkg::REG_SYNC, 32'h400);
        rd(trc_pkg::REG_SEQ, 32'h0);
        rd(trc_pkg::REG_CFG_CODE, 32'h8 | 4 << 13 | 1 << 16 | 4 << 17 | 4 << 20 | 1 << 23 | 3 << 24 | 1 << 26);
        rd(trc_pkg::REG_CFG_EXT, 32'h4 | 8 << 16 | 1 << 26);
        $display("test reset_values done");
        for (int i = 0; i < 9; i++) begin
            d = $urandom;
            wr(rw_addr[i], d);
            rd(rw_addr[i], d & rw_mask[i]);
        end
        tick(2);
        #1 check(ext_sel, d);
        wr(10'h3ff, $urandom);
        rd(10'h3ff, 32'h0);
        rd(10'h0c0, 32'h0);
        $display("test read_write done");
        for (int c = 0; c < 3; c++) begin
            v[c] = $urandom;
            wr(trc_pkg::REG_CID_VAL + 10'(c), v[c]);
        end
        wr(trc_pkg::REG_CID_MASK, 32'h0);
        for (int s = 0; s < 4; s++) begin
            d = $urandom;
            k = (s + 2) % 3;
            wr(trc_pkg::REG_ACC_TYPE, {d[31:10], 2'(s), d[7:0]});
            rd(trc_pkg::REG_ACC_TYPE, {16'h0, d[15:10], 2'(s), 5'h0, 3'h1});
            @(posedge mclk);
            addr_hit <= 16'h0001;
            cur_context_id <= v[k];
            tick(3);
            #1 check(addr_match[0], 1'b1);
            check(ctx_match, 3'b001 << k);
            @(posedge mclk);
            cur_context_id <= ~v[k];
            tick(3);
            #1 check(addr_match[0], s == 0);
        end
        wr(trc_pkg::REG_CID_MASK, '1);
        tick(2);
        #1 check(ctx_match, 3'h7);
        $display("test context_qualify done");
        d = $urandom;
        wr(trc_pkg::REG_VMID, d);
        @(posedge mclk);
        cur_vmid <= d[7:0];
        tick(2);
        #1 check(vmid_match, 1'b1);
        @(posedge mclk);
        cur_vmid <= ~d[7:0];
        tick(2);
        #1 check(vmid_match, 1'b0);
        for (int i = 0; i < 4; i++) begin
            d = ($urandom & 32'h0fff) + 32'h4;
            wr(trc_pkg::REG_CNT_RLD + 10'(i), d);
            @(posedge mclk);
            cnt_ev.reload[i] <= 1'b1;
            @(posedge mclk);
            cnt_ev.reload[i] <= 1'b0;
            cnt_ev.enable[i] <= 1'b1;
            repeat (2) @(posedge mclk);
            @(posedge mclk);
            cnt_ev <= '0;
            rd(trc_pkg::REG_CNT_VAL + 10'(i), d - 32'h3);
            #1 check(cnt_at_zero[i], 1'b0);
            wr(trc_pkg::REG_CNT_VAL + 10'(i), 32'h0);
            tick(2);
            #1 check(cnt_at_zero[i], 1'b1);
            @(posedge mclk);
            cnt_ev.enable[i] <= 1'b1;
            tick(2);
            cnt_ev <= '0;
            rd(trc_pkg::REG_CNT_VAL + 10'(i), 32'h0);
        end
        $display("test counters done");
        for (int i = 0; i < 3; i++) begin
            wr(trc_pkg::REG_SEQ, {30'h0, sq[i]});
            rd(trc_pkg::REG_SEQ, {30'h0, sq[i]});
            #1 check(seq_state, sq[i]);
        end
        wr(trc_pkg::REG_SEQ, 32'h3);
        rd(trc_pkg::REG_SEQ, 32'h0);
        @(posedge mclk);
        seq_ev_valid <= 1'b1;
        seq_ev_state <= trc_pkg::SEQ_STATE3;
        @(posedge mclk);
        seq_ev_valid <= 1'b0;
        tick(1);
        #1 check(seq_state, trc_pkg::SEQ_STATE3);
        @(posedge mclk);
        seq_ev_valid <= 1'b1;
        seq_ev_state <= 2'h3;
        @(posedge mclk);
        seq_ev_valid <= 1'b0;
        tick(1);
        #1 check(seq_state, trc_pkg::SEQ_STATE3);
        $display("test sequencer done");
        wr(trc_pkg::REG_MAIN_CTL, '1);
        rd(trc_pkg::REG_MAIN_CTL, 32'h1100);
        #1 check({branch_all, cyc_acc}, 2'b11);
        wr(trc_pkg::REG_MAIN_CTL, 32'h0);
        rd(trc_pkg::REG_MAIN_CTL, 32'h0);
        #1 check({branch_all, cyc_acc}, 2'b00);
        $display("test main_control done");
        wr(trc_pkg::REG_SYNC, 32'h4);
        k = sync_cnt;
        @(posedge mclk);
        trace_byte <= 1'b1;
        repeat (12) @(posedge mclk);
        trace_byte <= 1'b0;
        tick(4);
        check(32'(sync_cnt - k), 32'h3);
        $display("test sync_period done");
        tick(4);
        check(32'(exp_q.size()), 32'h0);
        test_done();
    end
endmodule

// ### inc/trc_pkg.sv
package trc_pkg;

    // ------------------------------------------------------------
    // register numbers
    // ------------------------------------------------------------
    localparam logic [9:0] REG_MAIN_CTL = 10'h000;
    localparam logic [9:0] REG_CFG_CODE = 10'h001;
    localparam logic [9:0] REG_ACC_TYPE = 10'h020;
    localparam logic [9:0] REG_CNT_RLD  = 10'h050;
    localparam logic [9:0] REG_CNT_VAL  = 10'h05c;
    localparam logic [9:0] REG_SEQ      = 10'h067;
    localparam logic [9:0] REG_CID_VAL  = 10'h06c;
    localparam logic [9:0] REG_CID_MASK = 10'h06f;
    localparam logic [9:0] REG_SYNC     = 10'h078;
    localparam logic [9:0] REG_CFG_EXT  = 10'h07a;
    localparam logic [9:0] REG_EXT_SEL  = 10'h07b;
    localparam logic [9:0] REG_VMID     = 10'h090;

    // ------------------------------------------------------------
    // field positions and values
    // ------------------------------------------------------------
    localparam int         CTL_BRANCH_ALL = 8;
    localparam int         CTL_CYC_ACC    = 12;
    localparam logic [2:0] ACC_TYPE_EXEC  = 3'h1;
    localparam logic [1:0] SEQ_STATE1     = 2'h0;
    localparam logic [1:0] SEQ_STATE2     = 2'h1;
    localparam logic [1:0] SEQ_STATE3     = 2'h2;
    localparam logic [11:0] SYNC_RESET    = 12'h400;
    localparam int CCR_ADDR_LSB   = 0;
    localparam int CCR_CNT_LSB    = 13;
    localparam int CCR_SEQ_BIT    = 16;
    localparam int CCR_EXTIN_LSB  = 17;
    localparam int CCR_EXTOUT_LSB = 20;
    localparam int CCR_FIFO_BIT   = 23;
    localparam int CCR_CID_LSB    = 24;
    localparam int CCR_SSTOP_BIT  = 26;
    localparam int CCE_SEL_LSB    = 0;
    localparam int CCE_BUSW_LSB   = 3;
    localparam int CCE_INSTR_LSB  = 13;
    localparam int CCE_WP_LSB     = 16;
    localparam int CCE_WPSS_BIT   = 20;
    localparam int CCE_WPCTL_BIT  = 21;
    localparam int CCE_TS_BIT     = 22;
    localparam int CCE_RSTK_BIT   = 23;
    localparam int CCE_VMID_BIT   = 26;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [9:0]  addr;
        logic [31:0] wdata;
    } trc_bus_req_s;

    typedef struct packed {
        logic [3:0] enable;
        logic [3:0] reload;
    } trc_cnt_ev_s;

endpackage

// ### rtl/trc_resource_regs.sv
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
module trc_resource_regs #(
    parameter int NUM_ADDR_PAIRS = 8,
    parameter int NUM_CTX        = 3,
    parameter int NUM_CNT        = 4,
    parameter bit HAS_SEQ        = 1'b1,
    parameter int NUM_EXT_IN     = 4,
    parameter int NUM_EXT_OUT    = 4,
    parameter int NUM_WP         = 8,
    parameter bit HAS_VMID       = 1'b1,
    parameter int EXT_BUS_W      = 0,
    parameter int NUM_EXT_SEL    = 4,
    parameter int NUM_INSTR      = 0,
    parameter bit HAS_FIFO_STALL = 1'b1,
    parameter bit HAS_SSTOP      = 1'b1,
    parameter bit HAS_BRANCH_ALL = 1'b1,
    parameter bit HAS_CYC_ACC    = 1'b1,
    parameter bit HAS_WP_CTL     = 1'b0,
    parameter bit HAS_WP_SSTOP   = 1'b0,
    parameter bit HAS_RET_STACK  = 1'b0,
    parameter bit HAS_TSTAMP     = 1'b0
) (
    input  wire logic                mclk,
    input  wire logic                rst_n,
    input  wire trc_pkg::trc_bus_req_s bus,
    output logic [31:0]              rdata,
    input  wire logic [15:0]         addr_hit,
    input  wire logic [31:0]         cur_context_id,
    input  wire logic [7:0]          cur_vmid,
    input  wire trc_pkg::trc_cnt_ev_s cnt_ev,
    input  wire logic                seq_ev_valid,
    input  wire logic [1:0]          seq_ev_state,
    input  wire logic                trace_byte,
    output logic [15:0]              addr_match,
    output logic [2:0]               ctx_match,
    output logic                     vmid_match,
    output logic [3:0]               cnt_at_zero,
    output logic [1:0]               seq_state,
    output logic                     sync_req,
    output logic [31:0]              ext_sel,
    output logic                     branch_all,
    output logic                     cyc_acc
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (NUM_ADDR_PAIRS < 0 || NUM_ADDR_PAIRS > 8 || NUM_CTX < 0 || NUM_CTX > 3
        || NUM_CNT < 0 || NUM_CNT > 4 || NUM_EXT_IN < 0 || NUM_EXT_IN > 4
        || NUM_EXT_OUT < 0 || NUM_EXT_OUT > 4 || NUM_WP < 0 || NUM_WP > 8
        || EXT_BUS_W < 0 || EXT_BUS_W > 255 || NUM_EXT_SEL < 0 || NUM_EXT_SEL > 4
        || NUM_INSTR < 0 || NUM_INSTR > 4) begin : g_bad
        $error("trc_resource_regs: parameter out of range");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0][7:0]  acc_ctl;
        logic [3:0][15:0]  reload;
        logic [3:0][15:0]  value;
        logic [1:0]        seq;
        logic [2:0][31:0]  cid;
        logic [31:0]       cid_mask;
        logic [7:0]        vmid;
        logic [11:0]       sync_freq;
        logic [11:0]       sync_cnt;
        logic [31:0]       ext_sel;
        logic              branch_all;
        logic              cyc_acc;
        logic [15:0]       addr_match;
        logic [2:0]        ctx_match;
        logic              vmid_match;
        logic [3:0]        at_zero;
        logic              sync_req;
        logic [31:0]       rdata;
    } trc_state_s;

    trc_state_s st;
    trc_state_s next_st;
    logic [31:0] cfg_code;
    logic [31:0] cfg_ext;

    // ------------------------------------------------------------
    // configuration codes
    // ------------------------------------------------------------
    always_comb begin
        cfg_code = 32'h0;
        cfg_ext  = 32'h0;
        cfg_code[trc_pkg::CCR_ADDR_LSB +: 4] = 4'(NUM_ADDR_PAIRS);
        cfg_code[trc_pkg::CCR_CNT_LSB +: 3] = 3'(NUM_CNT);
        cfg_code[trc_pkg::CCR_SEQ_BIT] = HAS_SEQ;
        cfg_code[trc_pkg::CCR_EXTIN_LSB +: 3]  = 3'(NUM_EXT_IN);
        cfg_code[trc_pkg::CCR_EXTOUT_LSB +: 3] = 3'(NUM_EXT_OUT);
        cfg_code[trc_pkg::CCR_FIFO_BIT]  = HAS_FIFO_STALL;
        cfg_code[trc_pkg::CCR_SSTOP_BIT] = HAS_SSTOP;
        cfg_code[trc_pkg::CCR_CID_LSB +: 2] = 2'(NUM_CTX);
        cfg_ext[trc_pkg::CCE_SEL_LSB +: 3]  = 3'(NUM_EXT_SEL);
        cfg_ext[trc_pkg::CCE_BUSW_LSB +: 8] = 8'(EXT_BUS_W);
        cfg_ext[trc_pkg::CCE_INSTR_LSB +: 3] = 3'(NUM_INSTR);
        cfg_ext[trc_pkg::CCE_WP_LSB +: 4] = 4'(NUM_WP);
        cfg_ext[trc_pkg::CCE_VMID_BIT]    = HAS_VMID;
        cfg_ext[trc_pkg::CCE_WPSS_BIT]  = HAS_WP_SSTOP;
        cfg_ext[trc_pkg::CCE_WPCTL_BIT] = HAS_WP_CTL;
        cfg_ext[trc_pkg::CCE_TS_BIT]    = HAS_TSTAMP;
        cfg_ext[trc_pkg::CCE_RSTK_BIT]  = HAS_RET_STACK;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [3:0]  idx;
        logic        sel_acc;
        logic        sel_rld;
        logic        sel_val;
        logic        sel_cid;
        logic [1:0]  csel;
        next_st = st;
        csel    = 2'h0;
        idx     = bus.addr[3:0];
        sel_acc = bus.addr[9:4] == trc_pkg::REG_ACC_TYPE[9:4]
                  && 32'(idx) < 2 * NUM_ADDR_PAIRS;
        sel_rld = bus.addr[9:2] == trc_pkg::REG_CNT_RLD[9:2] && 32'(idx[1:0]) < NUM_CNT;
        sel_val = bus.addr[9:2] == trc_pkg::REG_CNT_VAL[9:2] && 32'(idx[1:0]) < NUM_CNT;
        sel_cid = bus.addr[9:2] == trc_pkg::REG_CID_VAL[9:2] && 32'(idx[1:0]) < NUM_CTX;

        // counters: reload beats enable, decrement stops at zero
        for (int i = 0; i < 4; i++) begin
            if (i < NUM_CNT) begin
                if (cnt_ev.reload[i]) begin
                    next_st.value[i] = st.reload[i];
                end else if (cnt_ev.enable[i] && st.value[i] != 16'h0) begin
                    next_st.value[i] = st.value[i] - 16'h1;
                end
            end
        end

        // sequencer follows transition events
        if (HAS_SEQ && seq_ev_valid && seq_ev_state != 2'h3) begin
            next_st.seq = seq_ev_state;
        end

        // masked bits are ignored in every context ID compare
        for (int c = 0; c < 3; c++) begin
            next_st.ctx_match[c] = c < NUM_CTX
                && ((cur_context_id ^ st.cid[c]) & ~st.cid_mask) == 32'h0;
        end
        next_st.vmid_match = HAS_VMID && cur_vmid == st.vmid;

        for (int a = 0; a < 16; a++) begin
            csel = st.acc_ctl[a][1:0];
            next_st.addr_match[a] = a < 2 * NUM_ADDR_PAIRS && addr_hit[a]
                && (csel == 2'h0 || st.ctx_match[csel - 2'h1]);
        end

        // periodic sync request, a zero frequency disables it
        next_st.sync_req = 1'b0;
        if (trace_byte && st.sync_freq != 12'h0) begin
            if (st.sync_cnt >= st.sync_freq - 12'h1) begin
                next_st.sync_cnt = 12'h0;
                next_st.sync_req = 1'b1;
            end else begin
                next_st.sync_cnt = st.sync_cnt + 12'h1;
            end
        end

        // software writes override hardware updates
        if (bus.wr) begin
            if (bus.addr == trc_pkg::REG_MAIN_CTL) begin
                next_st.branch_all = bus.wdata[trc_pkg::CTL_BRANCH_ALL] & HAS_BRANCH_ALL;
                next_st.cyc_acc    = bus.wdata[trc_pkg::CTL_CYC_ACC] & HAS_CYC_ACC;
            end
            // comparator control stored, type bits not
            if (sel_acc) begin
                next_st.acc_ctl[idx] = bus.wdata[15:8];
            end
            if (sel_rld) begin
                next_st.reload[idx[1:0]] = bus.wdata[15:0];
            end
            if (sel_val) begin
                next_st.value[idx[1:0]] = bus.wdata[15:0];
            end
            // only the three legal codes are taken
            if (HAS_SEQ && bus.addr == trc_pkg::REG_SEQ && bus.wdata[1:0] != 2'h3) begin
                next_st.seq = bus.wdata[1:0];
            end
            if (sel_cid) begin
                next_st.cid[idx[1:0]] = bus.wdata;
            end
            if (NUM_CTX > 0 && bus.addr == trc_pkg::REG_CID_MASK) begin
                next_st.cid_mask = bus.wdata;
            end
            if (HAS_VMID && bus.addr == trc_pkg::REG_VMID) begin
                next_st.vmid = bus.wdata[7:0];
            end
            if (bus.addr == trc_pkg::REG_SYNC) begin
                next_st.sync_freq = bus.wdata[11:0];
            end
            // selectors beyond the implemented count read zero
            if (bus.addr == trc_pkg::REG_EXT_SEL) begin
                for (int s = 0; s < 4; s++) begin
                    next_st.ext_sel[8*s +: 8] = s < NUM_EXT_SEL ? bus.wdata[8*s +: 8] : 8'h0;
                end
            end
        end

        for (int i = 0; i < 4; i++) begin
            next_st.at_zero[i] = i < NUM_CNT && next_st.value[i] == 16'h0;
        end

        // read data stands for one cycle only
        next_st.rdata = 32'h0;
        if (bus.rd) begin
            if (bus.addr == trc_pkg::REG_MAIN_CTL) begin
                next_st.rdata[trc_pkg::CTL_BRANCH_ALL] = st.branch_all;
                next_st.rdata[trc_pkg::CTL_CYC_ACC]    = st.cyc_acc;
            end
            if (bus.addr == trc_pkg::REG_CFG_CODE) begin
                next_st.rdata = cfg_code;
            end
            if (bus.addr == trc_pkg::REG_CFG_EXT) begin
                next_st.rdata = cfg_ext;
            end
            // access type reads as instruction execute
            if (sel_acc) begin
                next_st.rdata = {16'h0, st.acc_ctl[idx], 5'h0, trc_pkg::ACC_TYPE_EXEC};
            end
            if (sel_rld) begin
                next_st.rdata = {16'h0, st.reload[idx[1:0]]};
            end
            if (sel_val) begin
                next_st.rdata = {16'h0, st.value[idx[1:0]]};
            end
            if (HAS_SEQ && bus.addr == trc_pkg::REG_SEQ) begin
                next_st.rdata = {30'h0, st.seq};
            end
            if (sel_cid) begin
                next_st.rdata = st.cid[idx[1:0]];
            end
            if (NUM_CTX > 0 && bus.addr == trc_pkg::REG_CID_MASK) begin
                next_st.rdata = st.cid_mask;
            end
            if (HAS_VMID && bus.addr == trc_pkg::REG_VMID) begin
                next_st.rdata = {24'h0, st.vmid};
            end
            if (bus.addr == trc_pkg::REG_SYNC) begin
                next_st.rdata = {20'h0, st.sync_freq};
            end
            if (bus.addr == trc_pkg::REG_EXT_SEL) begin
                next_st.rdata = st.ext_sel;
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st           <= '0;
            st.seq       <= trc_pkg::SEQ_STATE1;
            st.sync_freq <= trc_pkg::SYNC_RESET;
            st.at_zero   <= 4'h0;
        end else begin
            st <= next_st;
        end
    end

    assign rdata       = st.rdata;
    assign addr_match  = st.addr_match;
    assign ctx_match   = st.ctx_match;
    assign vmid_match  = st.vmid_match;
    assign cnt_at_zero = st.at_zero;
    assign seq_state   = st.seq;
    assign sync_req    = st.sync_req;
    assign ext_sel     = st.ext_sel;
    assign branch_all  = st.branch_all;
    assign cyc_acc     = st.cyc_acc;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_acc_type_ro: assert property (
        bus.rd && bus.addr == trc_pkg::REG_ACC_TYPE && NUM_ADDR_PAIRS > 0
        |=> rdata[2:0] == 3'h1)
        else $error("access type field not 001");

    chk_ctx_qual: assert property (
        st.acc_ctl[0][1:0] == 2'h2 && !st.ctx_match[1] |=> !addr_match[0])
        else $error("address match without context hit");

    chk_reload_load: assert property (
        NUM_CNT > 0 && cnt_ev.reload[0] && !bus.wr
        |=> st.value[0] == $past(st.reload[0]))
        else $error("counter did not reload");

    chk_cnt_read: assert property (
        NUM_CNT > 0 && bus.rd && bus.addr == trc_pkg::REG_CNT_VAL
        |=> rdata == {16'h0, $past(st.value[0])} ##1 rdata == 32'h0 || $past(bus.rd))
        else $error("counter value read wrong");

    chk_seq_code: assert property (
        seq_state != 2'h3)
        else $error("illegal sequencer code");

    chk_cid_mask: assert property (
        NUM_CTX > 0 && ((cur_context_id ^ st.cid[0]) & ~st.cid_mask) == 32'h0
        |=> ctx_match[0])
        else $error("masked context compare missed");

    chk_sync_reset: assert property (
        $past(!rst_n) |-> st.sync_freq == 12'h400 && seq_state == 2'h0)
        else $error("sync frequency reset value wrong");

    chk_ccr_counts: assert property (
        bus.rd && bus.addr == trc_pkg::REG_CFG_CODE
        |=> rdata[3:0] == 4'(NUM_ADDR_PAIRS) && rdata[15:13] == 3'(NUM_CNT))
        else $error("config code counts wrong");

    chk_ctl_gate: assert property (
        bus.wr && bus.addr == trc_pkg::REG_MAIN_CTL && bus.wdata[8]
        |=> branch_all == HAS_BRANCH_ALL)
        else $error("trace all branches bit gate wrong");

    chk_ext_sel: assert property (
        NUM_EXT_SEL == 4 && bus.wr && bus.addr == trc_pkg::REG_EXT_SEL
        |=> ext_sel == $past(bus.wdata))
        else $error("selector register not updated");

endmodule
